/* File: bench/mapp_host_properties.sv */
`default_nettype none
module mapp_host_properties
   import mapp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire mapp_pins_t pins,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Reset parks the port
   property p_rst_idle;
      disable iff (1'b0) !aresetn && ce |=> pins.read_strobe_n && pins.write_strobe_n
         && !pins.data_oe && !pins.interface_reset_n && !irq;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("port not idle in reset");
   property p_mem_quiet;
      !pins.interface_reset_n |-> pins.read_strobe_n && pins.write_strobe_n && !pins.data_oe;
   endproperty
   a_mem_quiet: assert property (p_mem_quiet) else $error("strobe while held");
   property p_sel_hold;
      pins.interface_reset_n && $past(pins.interface_reset_n) |-> $stable(pins.port_select);
   endproperty
   a_sel_hold: assert property (p_sel_hold) else $error("select moved");
   // Address steady at both latch edges
   property p_row_hold;
      $fell(pins.row_col_strobe) |-> $stable(pins.address_pins);
   endproperty
   a_row_hold: assert property (p_row_hold) else $error("row moved at fall");
   property p_col_hold;
      $rose(pins.row_col_strobe) |-> $stable(pins.address_pins);
   endproperty
   a_col_hold: assert property (p_col_hold) else $error("column moved at rise");
   property p_rw_excl;
      !(!pins.read_strobe_n && !pins.write_strobe_n);
   endproperty
   a_rw_excl: assert property (p_rw_excl) else $error("both strobes low");
   property p_rd_float;
      !pins.read_strobe_n |-> !pins.data_oe && pins.row_col_strobe;
   endproperty
   a_rd_float: assert property (p_rd_float) else $error("bus driven in read");
   property p_wr_drive;
      !pins.write_strobe_n |-> pins.data_oe && pins.row_col_strobe;
   endproperty
   a_wr_drive: assert property (p_wr_drive) else $error("bus undriven in write");
   property p_wr_data;
      !pins.write_strobe_n |=> pins.write_strobe_n || $stable(pins.data_out);
   endproperty
   a_wr_data: assert property (p_wr_data) else $error("data moved in write");
   // Register bus answers
   property p_ar_ans;
      ce && s_axi_arvalid && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid;
   endproperty
   a_ar_ans: assert property (p_ar_ans) else $error("late read answer");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_b_ans;
      s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_ans: assert property (p_b_ans) else $error("late write answer");
   c_wr: cover property (!pins.write_strobe_n);
   c_rd: cover property (!pins.read_strobe_n);
   c_irq: cover property ($rose(irq));
endmodule
bind mapp_host mapp_host_properties u_props (.aclk(aclk), .aresetn(aresetn), .ce(ce),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pins(pins), .irq(irq));
`default_nettype wire

/* File: bench/mapp_mem_model.sv */
`default_nettype none
module mapp_mem_model
   import mapp_pkg::*;
#(parameter int BUSY_LEN = 200)
(
   input wire logic aclk,
   input wire mapp_pins_t pins,
   output logic [DATA_W-1:0] data_pins_in,
   output logic ready_busy_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Supplies held good, so no lockout or fast mode
   localparam logic supply_lockout_flag = 1'b0;
   localparam logic program_supply_low = 1'b0;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] last = 8'h5a;
   logic prev_rc = 1'b1;
   logic prev_w = 1'b1;
   logic sel = 1'b0;
   int busy = 0;
   logic live;
   assign live = pins.interface_reset_n && sel && !supply_lockout_flag;
   // Read data only under the read strobe, else a changing pattern
   assign data_pins_in = (live && !pins.read_strobe_n) ? mem[addr] : ~last;
   assign ready_busy_out = (busy == 0);
   // Address halves, byte store and busy time
   always @(posedge aclk) begin
      last <= data_pins_in;
      prev_rc <= pins.row_col_strobe;
      prev_w <= pins.write_strobe_n;
      if (!pins.interface_reset_n) sel <= pins.port_select;
      if (live && prev_rc && !pins.row_col_strobe) addr[10:0] <= pins.address_pins;
      if (live && !prev_rc && pins.row_col_strobe) addr[18:11] <= pins.address_pins[7:0];
      if (live && !prev_w && pins.write_strobe_n && busy == 0 && !program_supply_low) begin
         mem[addr] <= pins.data_out;
         busy <= BUSY_LEN;
      end else if (busy != 0) begin
         busy <= busy - 1;
      end
   end
endmodule
`default_nettype wire

/* File: bench/test_mapp_host.sv */
`default_nettype none
module test_mapp_host
   import mapp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, ce = 1;
   logic [7:0] awaddr = 0, araddr = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, irq, rb;
   logic [31:0] wdata = 0, rdata, r;
   logic [1:0] bresp, rresp;
   logic [DATA_W-1:0] dq, d;
   logic [ADDR_W-1:0] a;
   mapp_pins_t pins;
   logic [33:0] bq[$], rq[$];
   int num_errors = 0, samples_checked = 0;
   always #12.5 aclk = ~aclk;
   mapp_host u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins),
      .data_pins_in(dq), .ready_busy_out(rb), .irq(irq));
   mapp_mem_model #(.BUSY_LEN(200)) u_mem (.aclk(aclk), .pins(pins), .data_pins_in(dq),
      .ready_busy_out(rb));
   task automatic chk(input logic [33:0] s, input logic [33:0] e);
      samples_checked++;
      if (s !== e) begin
         num_errors++;
         $display("[ERR] %0t saw %h want %h", $time, s, e);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] v, input logic [1:0] e);
      bq.push_back({e, 32'h0});
      @(posedge aclk);
      awaddr <= ad;
      wdata <= v;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      // Each channel is released once its own ready has been sampled high
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] v, input logic [1:0] e);
      rq.push_back({e, v});
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      while (!rvalid) @(posedge aclk);
      rready <= 0;
   endtask
   // Answers are matched against the oldest note
   always @(posedge aclk) begin
      if (bvalid && bready) chk({bresp, 32'h0}, bq.pop_front());
      if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
   end
   task automatic wirq();
      for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge aclk);
      #1 chk(34'(irq), 34'h1);
   endtask
   task automatic wrb();
      for (int n = 0; n < 3000 && rb !== 1'b1; n++) @(posedge aclk);
   endtask
   task automatic cyc(input logic [ADDR_W-1:0] ad, input logic [7:0] v, input logic w);
      wr(REG_ADDR, 32'(ad), MAPP_RESP_OKAY);
      wr(REG_WDATA, 32'(v), MAPP_RESP_OKAY);
      wr(REG_CTRL, {28'h0, 2'b11, w, 1'b1}, MAPP_RESP_OKAY);
      wirq();
      wr(REG_IRQ_STAT, 32'h1, MAPP_RESP_OKAY);
   endtask
   // Hang guard
   initial begin
      repeat (40000) @(posedge aclk);
      num_errors++;
      test_done();
   end
   initial begin
      r = $urandom(32'hb47771f9);
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      rd(REG_CTRL, CTRL_RST, MAPP_RESP_OKAY);
      rd(REG_TIMING, {24'h0, TIMING_RST}, MAPP_RESP_OKAY);
      rd(REG_IRQ_MASK, 32'h0, MAPP_RESP_OKAY);
      rd(8'h40, 32'h0, MAPP_RESP_SLVERR);
      wr(8'h40, 32'h1, MAPP_RESP_SLVERR);
      chk(34'(pins.interface_reset_n), 34'h0);
      chk(34'(pins.port_select), 34'h1);
      wr(REG_IRQ_MASK, 32'h1, MAPP_RESP_OKAY);
      wr(REG_CTRL, 32'hc, MAPP_RESP_OKAY);
      // Random write then read back at random pace
      for (int i = 0; i < 4; i++) begin
         r = $urandom;
         a = r[ADDR_W-1:0];
         d = r[31:24];
         wr(REG_TIMING, 32'($urandom_range(3)), MAPP_RESP_OKAY);
         cyc(a, d, 1'b1);
         chk(34'(u_mem.mem[a]), 34'(d));
         wrb();
         cyc(a, ~d, 1'b0);
         rd(REG_RDATA, {24'h0, d}, MAPP_RESP_OKAY);
      end
      // Ready edges of the loop are cleared first
      wr(REG_IRQ_STAT, 32'h2, MAPP_RESP_OKAY);
      // Second write while busy is refused and flagged
      cyc(a, d, 1'b1);
      cyc(a, ~d, 1'b1);
      chk(34'(u_mem.mem[a]), 34'(d));
      rd(REG_IRQ_STAT, 32'h4, MAPP_RESP_OKAY);
      rd(REG_STATUS, 32'h0, MAPP_RESP_OKAY);
      wr(REG_IRQ_MASK, 32'h0, MAPP_RESP_OKAY);
      wrb();
      repeat (3) @(posedge aclk);
      chk(34'(irq), 34'h0);
      rd(REG_IRQ_STAT, 32'h6, MAPP_RESP_OKAY);
      wr(REG_IRQ_MASK, 32'h2, MAPP_RESP_OKAY);
      wirq();
      rd(REG_STATUS, 32'h2, MAPP_RESP_OKAY);
      wr(REG_IRQ_STAT, 32'h6, MAPP_RESP_OKAY);
      rd(REG_IRQ_STAT, 32'h0, MAPP_RESP_OKAY);
      chk(34'(irq), 34'h0);
      // Clock enable low freezes the bus slave until it returns
      @(posedge aclk);
      ce <= 0;
      fork
         wr(REG_TIMING, 32'h3, MAPP_RESP_OKAY);
      join_none
      repeat (6) @(posedge aclk);
      chk(34'({awready, wready, bvalid}), 34'h0);
      ce <= 1;
      wait fork;
      rd(REG_TIMING, 32'h3, MAPP_RESP_OKAY);
      test_done();
   end
endmodule
`default_nettype wire

/* File: verilog/mapp_cycle.sv */
`default_nettype none
// Runs one strobe cycle on the multiplexed port; each step lasts step_len+1 clocks
module mapp_cycle
   import mapp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic start,
   input wire logic is_write,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [7:0] step_len,
   input wire logic [DATA_W-1:0] data_pins_in,
   output logic busy,
   output logic done,
   output logic [DATA_W-1:0] rdata,
   output mapp_pins_t pins
);
   typedef enum {S_IDLE, S_ROW, S_RCLO, S_COL, S_RCHI, S_STRB, S_HOLD} mapp_step_t;
   mapp_step_t st, next_st;
   logic [7:0] cnt, next_cnt;
   logic [DATA_W-1:0] next_rdata;
   mapp_pins_t next_pins;
   logic next_done;
   logic step_end;
   assign step_end = (cnt == step_len);
   assign busy = (st != S_IDLE);

   // Sequencer next state and pin values
   always_comb begin
      next_st = st;
      next_cnt = step_end ? 8'h00 : cnt + 8'h01;
      next_pins = pins;
      next_rdata = rdata;
      next_done = 1'b0;
      case (st)
         S_IDLE: begin
            next_cnt = 8'h00;
            if (start) begin
               next_pins.row_col_strobe = 1'b1;
               next_pins.address_pins = addr[ROW_W-1:0]; // RULE1
               next_st = S_ROW;
            end
         end
         S_ROW: if (step_end) begin
            next_pins.row_col_strobe = 1'b0; // RULE1
            next_st = S_RCLO;
         end
         S_RCLO: if (step_end) begin
            next_pins.address_pins = {{(ROW_W-COL_W){1'b0}}, addr[ADDR_W-1:ROW_W]}; // RULE2
            next_st = S_COL;
         end
         S_COL: if (step_end) begin
            next_pins.row_col_strobe = 1'b1; // RULE2
            next_st = S_RCHI;
         end
         S_RCHI: if (step_end) begin
            if (is_write) begin
               next_pins.data_out = wdata; // RULE4
               next_pins.data_oe = 1'b1;
               next_pins.write_strobe_n = 1'b0; // RULE6
            end else begin
               next_pins.read_strobe_n = 1'b0; // RULE5
            end
            next_st = S_STRB;
         end
         S_STRB: if (step_end) begin
            next_pins.read_strobe_n = 1'b1;
            next_pins.write_strobe_n = 1'b1;
            next_st = S_HOLD;
         end
         S_HOLD: begin
            // Host pins lag this sequencer by one register, so read data is taken here
            if (!is_write && cnt == 8'h00) begin
               next_rdata = data_pins_in; // RULE3 RULE5
            end
            if (step_end) begin
               next_pins.data_oe = 1'b0;
               next_done = 1'b1;
               next_st = S_IDLE;
            end
         end
         default: next_st = S_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= S_IDLE;
         cnt <= 8'h00;
         rdata <= '0;
         done <= 1'b0;
         pins.address_pins <= '0;
         pins.data_out <= '0;
         pins.data_oe <= 1'b0;
         pins.row_col_strobe <= 1'b1;
         pins.read_strobe_n <= 1'b1;
         pins.write_strobe_n <= 1'b1;
         pins.interface_reset_n <= 1'b0;
         pins.port_select <= 1'b1;
      end else if (ce) begin
         st <= next_st;
         cnt <= next_cnt;
         rdata <= next_rdata;
         done <= next_done;
         pins.address_pins <= next_pins.address_pins;
         pins.data_out <= next_pins.data_out;
         pins.data_oe <= next_pins.data_oe;
         pins.row_col_strobe <= next_pins.row_col_strobe;
         pins.read_strobe_n <= next_pins.read_strobe_n;
         pins.write_strobe_n <= next_pins.write_strobe_n;
      end
   end
endmodule
`default_nettype wire

/* File: verilog/mapp_host.sv */
`default_nettype none
// Functional notes
// (RULE1) The row address bits 10:0 are put on the address pins before the strobe falls.
// (RULE2) The column bits 18:11 are put on the same pins and latched as the strobe rises.
// (RULE3) In a read cycle the memory drives the byte at the latched address onto the data pins.
// (RULE4) In a write cycle the memory latches the data pins as a command or operand byte.
// (RULE5) The active-low read strobe governs reads and the memory drives data only while it is low.
// (RULE6) The active-low write strobe governs writes and is pulsed to deliver a command byte.
// (RULE7) While a program or erase runs the ready/busy line is low and new such commands are refused.
// (RULE8) When idle the ready/busy line is high and reads, programs and erases are accepted.
// (RULE9) Under supply lockout the memory ignores every write cycle.
// (RULE10) Supply lockout during a program or erase aborts it and leaves the data invalid.
// (RULE11) When supply lockout clears the command interface returns to read mode.
// (RULE12) With program supply low any program or erase is refused and flagged in status.
// (RULE13) With program supply high erase and quadruple-byte program run in fast mode.
// (RULE14) Only a subset of the memory's functions is reachable through this port.
// (RULE15) The port is chosen by a high select input at power-up or during reset and then held.
// (RULE16) While interface reset is low the memory floats its outputs and leaves reset in read mode.
// (RULE17) The memory hands the assembled address and written byte to a command decoder.
module mapp_host
   import mapp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output mapp_pins_t pins,
   input wire logic [DATA_W-1:0] data_pins_in,
   input wire logic ready_busy_out,
   output logic irq
);
   logic [31:0] ctrl, next_ctrl;
   logic [ADDR_W-1:0] addr_r, next_addr_r;
   logic [DATA_W-1:0] wdata_r, next_wdata_r;
   logic [7:0] timing, next_timing;
   logic [IRQ_W-1:0] istat, next_istat, imask, next_imask;
   logic rb_q, next_rb_q;
   logic next_irq;
   logic reset_pin, next_reset_pin;
   logic go, cyc_busy, cyc_done;
   logic [DATA_W-1:0] cyc_rdata;
   mapp_pins_t cyc_pins;
   logic [7:0] wa, next_wa;
   logic wa_ok, next_wa_ok, wd_ok, next_wd_ok;
   logic [31:0] wd, next_wd;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic wr_fire;

   assign wr_fire = wa_ok && wd_ok && !s_axi_bvalid;
   assign go = ctrl[CTRL_GO] && !cyc_busy && ctrl[CTRL_RESET];

   mapp_cycle u_cycle (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .start(go),
      .is_write(ctrl[CTRL_WRITE]),
      .addr(addr_r),
      .wdata(wdata_r),
      .step_len(timing),
      .data_pins_in(data_pins_in),
      .busy(cyc_busy),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .pins(cyc_pins)
   );

   // AXI slave channel handling and register writes
   always_comb begin
      next_wa = wa;
      next_wd = wd;
      next_wa_ok = wa_ok;
      next_wd_ok = wd_ok;
      next_awready = 1'b0;
      next_wready = 1'b0;
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      next_arready = 1'b0;
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rresp = s_axi_rresp;
      next_rdata = s_axi_rdata;
      next_ctrl = ctrl;
      next_addr_r = addr_r;
      next_wdata_r = wdata_r;
      next_timing = timing;
      next_imask = imask;
      next_reset_pin = reset_pin;
      next_rb_q = ready_busy_out;
      next_istat = istat;
      if (go) begin
         next_ctrl[CTRL_GO] = 1'b0;
      end
      if (s_axi_awvalid && !wa_ok && !s_axi_awready) begin
         next_awready = 1'b1;
         next_wa = s_axi_awaddr;
         next_wa_ok = 1'b1;
      end
      if (s_axi_wvalid && !wd_ok && !s_axi_wready) begin
         next_wready = 1'b1;
         next_wd = s_axi_wdata;
         next_wd_ok = 1'b1;
      end
      if (wr_fire) begin
         next_wa_ok = 1'b0;
         next_wd_ok = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = MAPP_RESP_OKAY;
         if (wa[7:2] == REG_CTRL[7:2]) begin
            next_ctrl = wd;
            next_reset_pin = wd[CTRL_RESET]; // RULE16
         end else if (wa[7:2] == REG_ADDR[7:2]) begin
            next_addr_r = wd[ADDR_W-1:0];
         end else if (wa[7:2] == REG_WDATA[7:2]) begin
            next_wdata_r = wd[DATA_W-1:0];
         end else if (wa[7:2] == REG_IRQ_STAT[7:2]) begin
            next_istat = istat & ~wd[IRQ_W-1:0];
         end else if (wa[7:2] == REG_IRQ_MASK[7:2]) begin
            next_imask = wd[IRQ_W-1:0];
         end else if (wa[7:2] == REG_TIMING[7:2]) begin
            next_timing = wd[7:0];
         end else if (wa[7:2] != REG_RDATA[7:2] && wa[7:2] != REG_STATUS[7:2]) begin
            next_bresp = MAPP_RESP_SLVERR;
         end
      end
      // Event capture: set wins over the write-one clear
      if (cyc_done) begin
         next_istat[IRQ_DONE] = 1'b1;
      end
      if (ready_busy_out && !rb_q) begin
         next_istat[IRQ_READY] = 1'b1; // RULE8
      end
      if (go && ctrl[CTRL_WRITE] && !ready_busy_out) begin
         next_istat[IRQ_BUSY_REJ] = 1'b1; // RULE7
      end
      if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
         next_arready = 1'b1;
         next_rvalid = 1'b1;
         next_rresp = MAPP_RESP_OKAY;
         next_rdata = 32'h0000_0000;
         if (s_axi_araddr[7:2] == REG_CTRL[7:2]) begin
            next_rdata = ctrl;
         end else if (s_axi_araddr[7:2] == REG_ADDR[7:2]) begin
            next_rdata[ADDR_W-1:0] = addr_r;
         end else if (s_axi_araddr[7:2] == REG_WDATA[7:2]) begin
            next_rdata[DATA_W-1:0] = wdata_r;
         end else if (s_axi_araddr[7:2] == REG_RDATA[7:2]) begin
            next_rdata[DATA_W-1:0] = cyc_rdata; // RULE3
         end else if (s_axi_araddr[7:2] == REG_STATUS[7:2]) begin
            next_rdata[1:0] = {ready_busy_out, cyc_busy};
         end else if (s_axi_araddr[7:2] == REG_IRQ_STAT[7:2]) begin
            next_rdata[IRQ_W-1:0] = istat;
         end else if (s_axi_araddr[7:2] == REG_IRQ_MASK[7:2]) begin
            next_rdata[IRQ_W-1:0] = imask;
         end else if (s_axi_araddr[7:2] == REG_TIMING[7:2]) begin
            next_rdata[7:0] = timing;
         end else begin
            next_rresp = MAPP_RESP_SLVERR;
         end
      end
   end

   assign next_irq = |(istat & imask);

   // Register stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RST;
         addr_r <= '0;
         wdata_r <= '0;
         timing <= TIMING_RST;
         istat <= '0;
         imask <= '0;
         rb_q <= 1'b1; // Idle level of ready/busy, so no false edge after reset
         reset_pin <= 1'b0;
         wa <= '0;
         wd <= '0;
         wa_ok <= 1'b0;
         wd_ok <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= MAPP_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= MAPP_RESP_OKAY;
         s_axi_rdata <= '0;
         irq <= 1'b0;
         pins <= '{address_pins: '0, data_out: '0, data_oe: 1'b0, row_col_strobe: 1'b1,
                   read_strobe_n: 1'b1, write_strobe_n: 1'b1, interface_reset_n: 1'b0,
                   port_select: 1'b1};
      end else if (ce) begin
         ctrl <= next_ctrl;
         addr_r <= next_addr_r;
         wdata_r <= next_wdata_r;
         timing <= next_timing;
         istat <= next_istat;
         imask <= next_imask;
         rb_q <= next_rb_q;
         reset_pin <= next_reset_pin;
         wa <= next_wa;
         wd <= next_wd;
         wa_ok <= next_wa_ok;
         wd_ok <= next_wd_ok;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rresp <= next_rresp;
         s_axi_rdata <= next_rdata;
         irq <= next_irq;
         pins <= cyc_pins;
         pins.interface_reset_n <= next_reset_pin; // RULE16
         // Port choice only moves while the memory is held in reset
         if (!pins.interface_reset_n) begin
            pins.port_select <= next_ctrl[CTRL_SELECT]; // RULE15
         end else begin
            pins.port_select <= pins.port_select;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/mapp_pkg.sv */
`default_nettype none
package mapp_pkg;
   // Register byte offsets on the AXI4-Lite slave
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_WDATA = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_IRQ_STAT = 8'h14;
   localparam logic [7:0] REG_IRQ_MASK = 8'h18;
   localparam logic [7:0] REG_TIMING = 8'h1c;
   // Control word fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_WRITE = 1;
   localparam int CTRL_RESET = 2;
   localparam int CTRL_SELECT = 3;
   // Interrupt bits
   localparam int IRQ_DONE = 0;
   localparam int IRQ_READY = 1;
   localparam int IRQ_BUSY_REJ = 2;
   localparam int IRQ_W = 3;
   // Reset values and widths
   localparam logic [7:0] TIMING_RST = 8'h02;
   localparam logic [31:0] CTRL_RST = 32'h0000_0008;
   localparam int ADDR_W = 19;
   localparam int ROW_W = 11;
   localparam int COL_W = 8;
   localparam int DATA_W = 8;
   // Pins toward the memory
   typedef struct packed {
      logic [ROW_W-1:0] address_pins;
      logic [DATA_W-1:0] data_out;
      logic data_oe;
      logic row_col_strobe;
      logic read_strobe_n;
      logic write_strobe_n;
      logic interface_reset_n;
      logic port_select;
   } mapp_pins_t;
   typedef enum logic [1:0] {
      MAPP_RESP_OKAY = 2'b00,
      MAPP_RESP_SLVERR = 2'b10
   } mapp_resp_t;
endpackage
`default_nettype wire
